// file: logic/bip_cfg.svh
// register map, field positions, reset values and timing of the ignition and pilot sequencer
`ifndef BIP_CFG_SVH
`define BIP_CFG_SVH
`define BIP_A_CTRL      12'h000
`define BIP_A_CMD       12'h004
`define BIP_A_TMR       12'h008
`define BIP_A_RELIGHT   12'h00C
`define BIP_A_STATUS    12'h010
`define BIP_F_RATIO     0
`define BIP_F_LFDIS     1
`define BIP_F_INCIN     2
`define BIP_F_POFF      3
`define BIP_F_FDRAFT    5
`define BIP_F_LHSMP     6
`define BIP_F_RLMODE    7
`define BIP_F_PID       8
`define BIP_F_NOASST    9
`define BIP_F_RLIM      12
`define BIP_F_MINP      16
`define BIP_F_CLR       0
`define BIP_F_LHSDLY    16
`define BIP_F_ST        0
`define BIP_F_FAILS     4
`define BIP_F_RLCNT     8
`define BIP_F_PROVEN    12
`define BIP_CTRL_RST    32'h0001_1000
`define BIP_TMR_RST     32'h000A_000A
`define BIP_RELIGHT_RST 16'h000A
`define BIP_FAIL_LIMIT  2'h3
`define BIP_CLK_NS      20
`define BIP_TICK_NS     1000000
`endif

// file: logic/bip_pkg.sv
// types of the ignition and pilot sequencer
package bip_pkg;
	typedef enum logic [3:0] {ST_WAITING, ST_PURGE, ST_REQ_PILOT, ST_IGNITION, ST_PILOT, ST_LOW_FIRE,
		ST_HIGH_FIRE, ST_INCIN, ST_INCIN_NA, ST_PID, ST_LOCKOUT} bip_state_t;
	typedef enum logic [1:0] {POFF_DISABLED, POFF_AT_SP, POFF_AFTER_MAIN, POFF_FOLLOW} bip_poff_t;
	typedef struct packed {
		logic pilot;
		logic ssv_a;
		logic ssv_b;
		logic card_valve;
		logic coil;
		logic ign_en;
		logic fan;
	} bip_outs_t;
	typedef struct packed {
		bip_state_t  state;
		logic [1:0]  fails;
		logic [3:0]  relights;
		logic        proven;
		logic        flame;
		logic        entry;
		logic        relighting;
		logic [15:0] tick_cnt;
		logic        tick;
		bip_outs_t   outs;
	} bip_core_t;
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] tmr;
		logic [15:0] relight;
		logic [31:0] rdata;
		logic        slverr;
		logic        clr;
	} bip_regs_t;
	typedef struct packed {
		logic [15:0] count;
		logic        expired;
	} bip_tmr_t;
endpackage

// file: logic/bip_cfg_if.sv
// configuration and status passed between register file and sequencer
`timescale 1ns/1ns
`default_nettype none
interface bip_cfg_if
	import bip_pkg::*;
();
	logic        ratio_en, low_fire_dis, incin_en, forced_draft, lhs_main_perm, relight_mode, pid_mode, no_assist;
	bip_poff_t   pilot_off;
	logic [3:0]  relight_limit, min_pilots;
	logic [15:0] pos_err_ms, lhs_delay_ms, relight_ms;
	logic        clr_lockout;
	bip_state_t  state;
	logic [1:0]  fails;
	logic [3:0]  relights;
	logic        proven;
	modport regs (output ratio_en, low_fire_dis, incin_en, forced_draft, lhs_main_perm, relight_mode, pid_mode,
		no_assist, pilot_off, relight_limit, min_pilots, pos_err_ms, lhs_delay_ms, relight_ms, clr_lockout,
		input state, fails, relights, proven);
	modport core (input ratio_en, low_fire_dis, incin_en, forced_draft, lhs_main_perm, relight_mode, pid_mode,
		no_assist, pilot_off, relight_limit, min_pilots, pos_err_ms, lhs_delay_ms, relight_ms, clr_lockout,
		output state, fails, relights, proven);
endinterface
`default_nettype wire

// file: logic/bip_tmr.sv
// millisecond timer that runs while its enable is held and flags when the limit is reached
`timescale 1ns/1ns
`default_nettype none
module bip_tmr
	import bip_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        tick,
	input  wire logic        run,
	input  wire logic [15:0] limit,
	output logic             expired
);
	bip_tmr_t q;
	bip_tmr_t d;

	always_comb
	begin
		d = q;
		if (!run)
			d = '0;
		else
		begin
			if (tick && q.count != limit)
				d.count = q.count + 16'h0001;
			d.expired = d.count == limit;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign expired = q.expired;
endmodule
`default_nettype wire

// file: logic/bip_apb_regs.sv
// APB register file: settings, lockout clear command and sequencer status
`timescale 1ns/1ns
`default_nettype none
`include "bip_cfg.svh"
module bip_apb_regs
	import bip_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pslverr,
	bip_cfg_if.regs          cfg
);
	bip_regs_t   q;
	bip_regs_t   d;
	logic [31:0] status;

	always_comb
	begin
		status = 32'h0000_0000;
		status[`BIP_F_ST +: 4] = cfg.state;
		status[`BIP_F_FAILS +: 2] = cfg.fails;
		status[`BIP_F_RLCNT +: 4] = cfg.relights;
		status[`BIP_F_PROVEN] = cfg.proven;
	end

	// read data and error are latched in setup so they stand through the zero-wait access phase
	always_comb
	begin
		d = q;
		d.clr = 1'b0;
		if (psel && !penable)
		begin
			d.slverr = 1'b0;
			unique case (paddr)
				`BIP_A_CTRL: d.rdata = q.ctrl;
				`BIP_A_CMD: d.rdata = 32'h0000_0000;
				`BIP_A_TMR: d.rdata = q.tmr;
				`BIP_A_RELIGHT: d.rdata = {16'h0000, q.relight};
				`BIP_A_STATUS: d.rdata = status;
				default:
				begin
					d.rdata = 32'h0000_0000;
					d.slverr = 1'b1;
				end
			endcase
		end
		if (psel && penable && pwrite)
		begin
			if (paddr == `BIP_A_CTRL)
				d.ctrl = pwdata;
			if (paddr == `BIP_A_CMD)
				d.clr = pwdata[`BIP_F_CLR];
			if (paddr == `BIP_A_TMR)
				d.tmr = pwdata;
			if (paddr == `BIP_A_RELIGHT)
				d.relight = pwdata[15:0];
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			q <= {`BIP_CTRL_RST, `BIP_TMR_RST, `BIP_RELIGHT_RST, 32'h0000_0000, 1'b0, 1'b0};
		else
			q <= d;
	end

	assign prdata = q.rdata;
	assign pslverr = q.slverr;
	assign cfg.ratio_en = q.ctrl[`BIP_F_RATIO];
	assign cfg.low_fire_dis = q.ctrl[`BIP_F_LFDIS];
	assign cfg.incin_en = q.ctrl[`BIP_F_INCIN];
	assign cfg.pilot_off = bip_poff_t'(q.ctrl[`BIP_F_POFF +: 2]);
	assign cfg.forced_draft = q.ctrl[`BIP_F_FDRAFT];
	assign cfg.lhs_main_perm = q.ctrl[`BIP_F_LHSMP];
	assign cfg.relight_mode = q.ctrl[`BIP_F_RLMODE];
	assign cfg.pid_mode = q.ctrl[`BIP_F_PID];
	assign cfg.no_assist = q.ctrl[`BIP_F_NOASST];
	assign cfg.relight_limit = q.ctrl[`BIP_F_RLIM +: 4];
	assign cfg.min_pilots = q.ctrl[`BIP_F_MINP +: 4];
	assign cfg.pos_err_ms = q.tmr[15:0];
	assign cfg.lhs_delay_ms = q.tmr[`BIP_F_LHSDLY +: 16];
	assign cfg.relight_ms = q.relight;
	assign cfg.clr_lockout = q.clr;
endmodule
`default_nettype wire

// file: logic/bip_top.sv
// ignition and pilot sequencer of the burner management controller
`timescale 1ns/1ns
`default_nettype none
`include "bip_cfg.svh"
module bip_top
	import bip_pkg::*;
#(
	parameter int TICK_CYCLES = `BIP_TICK_NS / `BIP_CLK_NS
)
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        alarm,
	input  wire logic        wait_cond,
	input  wire logic        user_stop,
	input  wire logic        flame,
	input  wire logic [3:0]  pilots_running,
	input  wire logic        ign_fail,
	input  wire logic        purge_done,
	input  wire logic        pilot_pos_proven,
	input  wire logic        lightoff_proven,
	input  wire logic        main_permissive,
	input  wire logic        temp_above_low_fire_sp,
	input  wire logic        temp_above_process_sp,
	input  wire logic        temp_above_wg_off_sp,
	input  wire logic        temp_above_wg_on_sp,
	output logic             pilot_out,
	output logic             main_shutoff_valve_a,
	output logic             main_shutoff_valve_b,
	output logic             pilot_card_valve,
	output logic             ign_coil,
	output logic             ign_enable,
	output logic             combustion_fan_output
);
	bip_cfg_if cfg ();
	bip_core_t q;
	bip_core_t d;
	logic      pos_exp;
	logic      lhs_exp;
	logic      rl_exp;
	logic      lock_req;
	logic      poff_ok;
	logic      rl_allowed;
	logic      flame_lost;
	logic      loss_over;
	logic      pilot_cause;
	logic      lhs_run;

	function automatic logic is_main(input bip_state_t s);
		return s inside {ST_LOW_FIRE, ST_HIGH_FIRE, ST_INCIN, ST_INCIN_NA, ST_PID};
	endfunction

	// ==========================================================
	// register file and timers
	assign pready = 1'b1;

	bip_apb_regs u_regs (
		.clock   (clock),
		.rst_n   (rst_n),
		.paddr   (paddr),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pslverr (pslverr),
		.cfg     (cfg)
	);

	bip_tmr u_pos_tmr (
		.clock   (clock),
		.rst_n   (rst_n),
		.tick    (q.tick),
		.run     (q.state == ST_PILOT),
		.limit   (cfg.pos_err_ms),
		.expired (pos_exp)
	);

	bip_tmr u_lhs_tmr (
		.clock   (clock),
		.rst_n   (rst_n),
		.tick    (q.tick),
		.run     (lhs_run),
		.limit   (cfg.lhs_delay_ms),
		.expired (lhs_exp)
	);

	bip_tmr u_rl_tmr (
		.clock   (clock),
		.rst_n   (rst_n),
		.tick    (q.tick),
		.run     (q.relighting),
		.limit   (cfg.relight_ms),
		.expired (rl_exp)
	);

	// ==========================================================
	// transition causes
	assign lock_req = alarm || user_stop;
	assign poff_ok = cfg.pilot_off == POFF_DISABLED || cfg.pilot_off == POFF_AT_SP;
	assign rl_allowed = q.state == ST_PILOT && cfg.relight_mode;
	// with relight on, a dropout in pilot becomes a loss only once the relight window is spent
	assign flame_lost = !q.entry && (rl_allowed ? (q.relighting && rl_exp && !flame) : (q.flame && !flame));
	assign loss_over = q.relights >= cfg.relight_limit;
	assign lhs_run = q.state == ST_PID && temp_above_process_sp && !temp_above_low_fire_sp && cfg.lhs_main_perm;
	assign pilot_cause = main_permissive
		|| ((q.state == ST_LOW_FIRE || q.state == ST_PID) && temp_above_low_fire_sp)
		|| (q.state == ST_HIGH_FIRE && temp_above_process_sp && cfg.low_fire_dis)
		|| (q.state == ST_INCIN_NA && temp_above_wg_off_sp);

	// ==========================================================
	// sequencer
	always_comb
	begin
		d = q;
		d.flame = flame;
		d.tick = 1'b0;
		d.tick_cnt = q.tick_cnt + 16'h0001;
		if (q.tick_cnt == 16'(TICK_CYCLES - 1))
		begin
			d.tick_cnt = 16'h0000;
			d.tick = 1'b1;
		end
		unique case (q.state)
			ST_WAITING:
			begin
				if (lock_req)
					d.state = ST_LOCKOUT;
				else if (!wait_cond)
					d.state = cfg.ratio_en ? ST_PURGE : ST_IGNITION;
			end
			ST_PURGE:
			begin
				if (lock_req)
					d.state = ST_LOCKOUT;
				else if (wait_cond)
					d.state = ST_WAITING;
				else if (purge_done)
					d.state = cfg.ratio_en ? ST_REQ_PILOT : ST_IGNITION;
			end
			ST_REQ_PILOT:
			begin
				if (lock_req)
					d.state = ST_LOCKOUT;
				else if (wait_cond)
					d.state = ST_WAITING;
				else if (pilot_pos_proven)
					d.state = ST_IGNITION;
			end
			ST_IGNITION:
			begin
				if (ign_fail)
					d.fails = q.fails + 2'h1;
				if (lock_req || (q.entry && flame) || (flame_lost && loss_over))
					d.state = ST_LOCKOUT;
				else if (ign_fail && q.fails == `BIP_FAIL_LIMIT - 2'h1)
					d.state = ST_LOCKOUT;
				else if (wait_cond || ign_fail || flame_lost)
					d.state = ST_WAITING;
				else if (flame && !q.entry && pilots_running >= cfg.min_pilots)
				begin
					d.state = ST_PILOT;
					d.proven = 1'b1;
					d.fails = 2'h0;
				end
				if (flame_lost && !loss_over)
					d.relights = q.relights + 4'h1;
			end
			ST_PILOT:
			begin
				if (lock_req || (flame_lost && loss_over))
					d.state = ST_LOCKOUT;
				else if (cfg.forced_draft && !lightoff_proven && pos_exp)
					d.state = ST_LOCKOUT;
				else if (wait_cond || flame_lost)
					d.state = ST_WAITING;
				else if (q.proven && !main_permissive)
				begin
					if (cfg.incin_en ? !temp_above_wg_on_sp : (!cfg.low_fire_dis && !temp_above_low_fire_sp))
						d.state = ST_LOW_FIRE;
					else if (cfg.low_fire_dis && !temp_above_process_sp)
						d.state = ST_HIGH_FIRE;
				end
				if (flame_lost && !loss_over)
					d.relights = q.relights + 4'h1;
				if (is_main(d.state))
					d.relights = 4'h0;
			end
			ST_LOW_FIRE, ST_HIGH_FIRE, ST_INCIN, ST_INCIN_NA, ST_PID:
			begin
				if (lock_req || (flame_lost && loss_over))
					d.state = ST_LOCKOUT;
				else if (wait_cond || flame_lost)
					d.state = ST_WAITING;
				else if (pilot_cause)
					d.state = poff_ok ? ST_PILOT : ST_WAITING;
				else if (lhs_run && lhs_exp)
					d.state = ST_PILOT;
				else if (q.state == ST_LOW_FIRE)
				begin
					if (cfg.incin_en && temp_above_wg_on_sp)
						d.state = cfg.no_assist ? ST_INCIN_NA : ST_INCIN;
					else if (!cfg.low_fire_dis && !temp_above_process_sp)
						d.state = cfg.pid_mode ? ST_PID : ST_HIGH_FIRE;
				end
				if (flame_lost && !loss_over)
					d.relights = q.relights + 4'h1;
			end
			ST_LOCKOUT:
			begin
				// only the software clear command or a reset gets the burner out of lockout
				if (cfg.clr_lockout)
				begin
					d.state = ST_WAITING;
					d.fails = 2'h0;
					d.relights = 4'h0;
				end
			end
		endcase
		if (d.state == ST_WAITING || d.state == ST_LOCKOUT)
			d.proven = 1'b0;
		d.entry = d.state == ST_IGNITION && q.state != ST_IGNITION;
		if (!rl_allowed || d.state != ST_PILOT)
			d.relighting = 1'b0;
		else if (q.flame && !flame)
			d.relighting = 1'b1;
		else if (flame)
			d.relighting = 1'b0;
		// outputs follow the state being entered so they change on the same edge as the state
		d.outs.fan = !(d.state == ST_WAITING || d.state == ST_LOCKOUT);
		d.outs.pilot = d.state == ST_IGNITION || d.state == ST_PILOT
			|| (is_main(d.state) && cfg.pilot_off != POFF_AFTER_MAIN);
		d.outs.card_valve = d.outs.pilot;
		d.outs.ssv_a = is_main(d.state) && d.proven;
		d.outs.ssv_b = d.outs.ssv_a && !(d.state == ST_LOW_FIRE && cfg.incin_en);
		d.outs.coil = d.state == ST_IGNITION || d.relighting;
		d.outs.ign_en = d.outs.coil;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign cfg.state = q.state;
	assign cfg.fails = q.fails;
	assign cfg.relights = q.relights;
	assign cfg.proven = q.proven;
	assign pilot_out = q.outs.pilot;
	assign main_shutoff_valve_a = q.outs.ssv_a;
	assign main_shutoff_valve_b = q.outs.ssv_b;
	assign pilot_card_valve = q.outs.card_valve;
	assign ign_coil = q.outs.coil;
	assign ign_enable = q.outs.ign_en;
	assign combustion_fan_output = q.outs.fan;

	// ==========================================================
	// checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_ign_entry;
		q.state != ST_IGNITION ##1 q.state == ST_IGNITION;
	endsequence

	sequence s_pilot_dropout;
		q.state == ST_PILOT && cfg.relight_mode && q.flame && !flame ##1 q.state == ST_PILOT;
	endsequence

	a_ign_outputs: assert property (
		q.state == ST_IGNITION |-> pilot_out && pilot_card_valve && ign_coil && ign_enable
			&& !main_shutoff_valve_a && !main_shutoff_valve_b)
		else $error("ignition outputs wrong");

	a_fuel_gate: assert property (
		main_shutoff_valve_a |-> q.proven && (is_main($past(q.state)) || $past(q.state) == ST_PILOT))
		else $error("main valve opened without proven pilot");

	a_wait_to_ign: assert property (
		q.state == ST_WAITING && !lock_req && !wait_cond && !cfg.ratio_en |=> q.state == ST_IGNITION)
		else $error("waiting did not go to ignition");

	a_alarm_lockout: assert property (
		(q.state == ST_IGNITION || q.state == ST_PILOT) && lock_req |=> q.state == ST_LOCKOUT)
		else $error("alarm or stop did not lock out");

	a_third_fail: assert property (
		q.state == ST_IGNITION && ign_fail && q.fails == 2'h2 |=> q.state == ST_LOCKOUT)
		else $error("third ignition failure did not lock out");

	a_fail_retry: assert property (
		q.state == ST_IGNITION && ign_fail && q.fails < 2'h2 && !lock_req && !(q.entry && flame) && !flame_lost
		|=> q.state == ST_WAITING && q.fails == $past(q.fails) + 2'h1)
		else $error("ignition failure not counted or not retried");

	a_early_flame: assert property (
		s_ign_entry ##0 flame |=> q.state == ST_LOCKOUT)
		else $error("flame at ignition entry did not lock out");

	a_loss_lockout: assert property (
		(q.state == ST_IGNITION || q.state == ST_PILOT) && flame_lost && loss_over |=> q.state == ST_LOCKOUT)
		else $error("flame loss past relight limit did not lock out");

	a_pilot_step: assert property (
		q.state == ST_IGNITION && !q.entry && flame && !ign_fail && !lock_req && !wait_cond
		&& pilots_running >= cfg.min_pilots |=> q.state == ST_PILOT && q.proven)
		else $error("ignition did not step to pilot");

	a_pilot_outputs: assert property (
		q.state == ST_PILOT |-> pilot_out && pilot_card_valve && !main_shutoff_valve_a
			&& !main_shutoff_valve_b && ign_coil == q.relighting && ign_enable == ign_coil)
		else $error("pilot outputs wrong");

	a_relight_drive: assert property (
		s_pilot_dropout |-> ign_coil && ign_enable)
		else $error("reignition did not drive coil");

	a_high_to_pilot: assert property (
		q.state == ST_HIGH_FIRE && !lock_req && !wait_cond && !flame_lost && temp_above_process_sp
		&& cfg.low_fire_dis && poff_ok |=> q.state == ST_PILOT)
		else $error("high fire did not drop to pilot");

	a_forced_lockout: assert property (
		q.state == ST_PILOT && cfg.forced_draft && !lightoff_proven && pos_exp |=> q.state == ST_LOCKOUT)
		else $error("unproven light-off did not lock out");

	a_purge_exit: assert property (
		q.state == ST_PURGE && purge_done && !lock_req && !wait_cond
		|=> q.state == (cfg.ratio_en ? ST_REQ_PILOT : ST_IGNITION))
		else $error("purge exit went to wrong state");

	a_wait_priority: assert property (
		q.state == ST_PILOT && wait_cond && !lock_req && !flame_lost && !(cfg.forced_draft && !lightoff_proven && pos_exp)
		|=> q.state == ST_WAITING)
		else $error("wait condition lost priority");
endmodule
`default_nettype wire

// file: test/bip_plant_model.sv
// plant model: pilot light-off and flame detector
`timescale 1ns/1ns
`default_nettype none
module bip_plant_model
(
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       pilot_out,
	input  wire logic       ign_coil,
	input  wire logic [1:0] mode,
	output logic            flame,
	output logic [3:0]      pilots_running
);
	// mode 0 lights after some spark cycles, 1 never lights, 2 false flame
	logic [1:0] spark_q;
	logic       lit_q;
	always_ff @(posedge clock)
	begin
		if (!rst_n || !pilot_out)
		begin
			spark_q <= 2'h0;
			lit_q   <= 1'h0;
		end
		else if (ign_coil && mode == 2'h0)
		begin
			if (spark_q == 2'h3)
				lit_q <= 1'h1;
			else
				spark_q <= spark_q + 2'h1;
		end
	end
	// lighting is delayed so no flame shows in the ignition entry cycle
	assign flame          = (mode == 2'h2) || (lit_q && mode == 2'h0);
	assign pilots_running = flame ? 4'h1 : 4'h0;
endmodule
`default_nettype wire

// file: test/bip_tb.sv
// self-checking bench of the ignition and pilot sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin bad_count++; $display("MISMATCH %0t %s", $time, m); end end
module burner_ignition_pilot_fsm_tb_top
	import bip_pkg::*;
;
	logic        clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        alarm = 0, wait_cond = 0, user_stop = 0, ign_fail = 0, main_perm = 0;
	logic        purge = 0, pos_ok = 0, lo_ok = 1, fan;
	logic        lf_sp = 1, pr_sp = 1, flame, pilot, va, vb, card, coil, ign_en;
	logic [3:0]  pilots;
	logic [1:0]  plant_mode = 2'h0;
	int          bad_count = 0, compares = 0;
	always #10 clock = ~clock;
	bip_top #(.TICK_CYCLES(4)) bip_top_inst (.clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .alarm(alarm), .wait_cond(wait_cond), .user_stop(user_stop), .flame(flame),
		.pilots_running(pilots), .ign_fail(ign_fail), .purge_done(purge), .pilot_pos_proven(pos_ok),
		.lightoff_proven(lo_ok), .main_permissive(main_perm), .temp_above_low_fire_sp(lf_sp),
		.temp_above_process_sp(pr_sp), .temp_above_wg_off_sp(1'h1), .temp_above_wg_on_sp(1'h1),
		.pilot_out(pilot), .main_shutoff_valve_a(va), .main_shutoff_valve_b(vb), .pilot_card_valve(card),
		.ign_coil(coil), .ign_enable(ign_en), .combustion_fan_output(fan));
	bip_plant_model bip_plant_model_inst (.clock(clock), .rst_n(rst_n), .pilot_out(pilot),
		.ign_coil(coil), .mode(plant_mode), .flame(flame), .pilots_running(pilots));
	task final_report;
		$display("counts: %0d compares, %0d mismatches", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// entered just after a rising edge; holds the request until pready is seen
	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int n;
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
		@(posedge clock);
		penable <= 1;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready !== 1'h1 && n < 20);
		if (pready !== 1'h1)
		begin
			$display("MISMATCH %0t no pready", $time);
			bad_count++;
			final_report();
		end
		rd = prdata; err = pslverr;
		psel <= 0; penable <= 0;
		@(posedge clock);
	endtask
	task wait_state(input logic [3:0] s);
		int n;
		n = 0;
		do
		begin
			apb(0, 12'h010, 32'h0);
			n++;
		end
		while (rd[3:0] !== s && n < 60);
		`CHK(rd[3:0], s, "state")
		if (rd[3:0] !== s)
			final_report();
	endtask
	task clear;
		apb(1, 12'h004, 32'h1);
	endtask
	task t_ignite;
		int n;
		n = 0;
		while (coil !== 1'h1 && n < 40)
		begin
			@(posedge clock);
			n++;
		end
		`CHK({pilot, va, vb, card, coil, ign_en}, 6'h27, "ignition outputs")
		if (coil !== 1'h1)
			final_report();
		wait_state(ST_PILOT);
		`CHK({pilot, va, vb, card, coil, ign_en}, 6'h24, "pilot outputs")
		`CHK(fan, 1'h1, "fan in pilot")
		$display("t_ignite done");
	endtask
	task t_regs;
		apb(0, 12'h000, 32'h0);
		`CHK(rd, 32'h0001_1000, "ctrl reset")
		apb(0, 12'h008, 32'h0);
		`CHK(rd, 32'h000A_000A, "tmr reset")
		apb(0, 12'hFFC, 32'h0);
		`CHK({err, rd}, {1'h1, 32'h0}, "unmapped")
		$display("t_regs done");
	endtask
	task t_main;
		lf_sp <= 0;
		wait_state(ST_LOW_FIRE);
		`CHK({va, vb}, 2'h3, "main valves open")
		main_perm <= 1;
		wait_state(ST_PILOT);
		main_perm <= 0;
		wait_state(ST_LOW_FIRE);
		lf_sp <= 1;
		wait_state(ST_PILOT);
		apb(1, 12'h000, 32'h0001_1002);
		pr_sp <= 0;
		wait_state(ST_HIGH_FIRE);
		pr_sp <= 1;
		wait_state(ST_PILOT);
		apb(1, 12'h000, 32'h0001_1000);
		$display("t_main done");
	endtask
	task t_flame_loss;
		plant_mode <= 2'h1;
		wait_state(ST_IGNITION);
		`CHK(rd[11:8], 4'h1, "relights")
		plant_mode <= 2'h0;
		wait_state(ST_PILOT);
		plant_mode <= 2'h1;
		wait_state(ST_LOCKOUT);
		$display("t_flame_loss done");
	endtask
	task t_entry;
		plant_mode <= 2'h2;
		wait_cond <= 1;
		clear();
		wait_state(ST_WAITING);
		wait_cond <= 0;
		wait_state(ST_LOCKOUT);
		$display("t_entry done");
	endtask
	task t_fails;
		plant_mode <= 2'h1;
		clear();
		for (int i = 1; i <= 3; i++)
		begin
			wait_state(ST_IGNITION);
			ign_fail <= 1;
			@(posedge clock);
			ign_fail <= 0;
			if (i < 3)
			begin
				wait_state(ST_IGNITION);
				`CHK(rd[5:4], 2'(i), "fail count")
			end
			else
				wait_state(ST_LOCKOUT);
		end
		$display("t_fails done");
	endtask
	task t_alarm;
		plant_mode <= 2'h0;
		clear();
		wait_state(ST_PILOT);
		alarm <= 1;
		wait_cond <= 1;
		wait_state(ST_LOCKOUT);
		`CHK(fan, 1'h0, "fan off in lockout")
		alarm <= 0;
		clear();
		wait_state(ST_WAITING);
		wait_cond <= 0;
		wait_state(ST_PILOT);
		wait_cond <= 1;
		wait_state(ST_WAITING);
		wait_cond <= 0;
		wait_state(ST_PILOT);
		user_stop <= 1;
		wait_state(ST_LOCKOUT);
		user_stop <= 0;
		$display("t_alarm done");
	endtask
	// ratio control on: purge, then pilot position request before ignition
	task t_purge;
		apb(1, 12'h000, 32'h0001_1001);
		clear();
		wait_state(ST_PURGE);
		purge <= 1;
		wait_state(ST_REQ_PILOT);
		purge <= 0;
		pos_ok <= 1;
		wait_state(ST_PILOT);
		$display("t_purge done");
	endtask
	task t_relight;
		apb(1, 12'h000, 32'h0001_1080);
		plant_mode <= 2'h1;
		repeat (3) @(posedge clock);
		`CHK({coil, ign_en}, 2'h3, "relight spark")
		plant_mode <= 2'h0;
		repeat (3) @(posedge clock);
		`CHK({coil, ign_en}, 2'h0, "relight ended")
		wait_state(ST_PILOT);
		$display("t_relight done");
	endtask
	// mid-run reset out of pilot: outputs drop and settings return to reset values
	task t_reset;
		rst_n <= 0;
		repeat (2) @(posedge clock);
		`CHK({pilot, va, vb, card, coil, ign_en, fan}, 7'h00, "outputs in reset")
		rst_n <= 1;
		apb(0, 12'h000, 32'h0);
		`CHK(rd, 32'h0001_1000, "ctrl after reset")
		wait_state(ST_PILOT);
		$display("t_reset done");
	endtask
	task t_forced;
		lo_ok <= 0;
		apb(1, 12'h000, 32'h0001_1020);
		wait_state(ST_LOCKOUT);
		`CHK(fan, 1'h0, "fan off after light-off timeout")
		lo_ok <= 1;
		apb(1, 12'h000, 32'h0001_1000);
		$display("t_forced done");
	endtask
	initial
	begin
		repeat (16) @(posedge clock);
		rst_n <= 1;
		t_ignite();
		t_regs();
		t_main();
		t_flame_loss();
		t_entry();
		t_fails();
		t_alarm();
		t_purge();
		t_relight();
		t_reset();
		t_forced();
		final_report();
	end
	initial
	begin
		#2000000;
		$display("MISMATCH %0t run timeout", $time);
		bad_count++;
		final_report();
	end
endmodule
`default_nettype wire
